// *** rtl/iaa_map.vh ***
`ifndef IAA_MAP_VH
`define IAA_MAP_VH

// ----------------------------------------------------------------
// Acknowledge cycle encodings
// ----------------------------------------------------------------
`define IAA_FC_CPU_SPACE 3'h7
`define IAA_ADDR_HI_ONES 20'hF_FFFF
`define IAA_ADDR_LSB 1'h1
`define IAA_ARB_SIU_RESET 4'hF
`define IAA_ARB_MOD_RESET 4'h0
`define IAA_ARB_ZERO 4'h0
`define IAA_ARB_MSB 3
`define IAA_LEVEL_NONE 3'h0
`define IAA_LEVEL_MAX 3'h7
`define IAA_LVL_PAD 5'h00
`define IAA_FC_NONE 3'h0
`define IAA_ADDR_ZERO 24'h00_0000
`define IAA_WORD_ZERO 16'h0000
`define IAA_ANS_IDLE 3'h7
`define IAA_DATA_ZERO 8'h00

// ----------------------------------------------------------------
// Vector numbers and table layout
// ----------------------------------------------------------------
`define IAA_VEC_SPURIOUS 8'h18
`define IAA_VEC_AUTO_BASE 8'h18
`define IAA_VEC_ADDR_SHIFT 2
`define IAA_VEC_NONE 8'h00
`define IAA_FETCH_PAD 6'h00
`define IAA_FETCH_ALIGN 2'h0

// ----------------------------------------------------------------
// Bus monitor timeout in cycles of clk_sys
// ----------------------------------------------------------------
`define IAA_BUSMON_CYCLES 8'h40
`define IAA_MON_ZERO 8'h00
`define IAA_MON_STEP 8'h01

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define IAA_NMOD 4
`define IAA_NSLOT 5
`define IAA_ARB_W 4

`endif

// *** rtl/iaa_contend.v ***
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Serial contention: bit by bit from msb, highest value wins
// ----------------------------------------------------------------
`include "iaa_map.vh"
module iaa_contend (
  input wire [`IAA_NSLOT-1:0] req,
  input wire [`IAA_NSLOT*`IAA_ARB_W-1:0] arb,
  output reg [`IAA_NSLOT-1:0] win,
  output reg any
);
  integer b;
  integer m;
  reg bus_bit;
  reg [`IAA_NSLOT-1:0] alive;

  // Wired-or per bit; a module that drives 0 while the bus reads 1 drops out
  always @* begin
    alive = req;
    bus_bit = 1'b0;
    for (b = `IAA_ARB_MSB; b >= 0; b = b - 1) begin
      bus_bit = 1'b0;
      for (m = 0; m < `IAA_NSLOT; m = m + 1) begin
        if (alive[m] && arb[m*`IAA_ARB_W+b]) begin
          bus_bit = 1'b1;
        end
      end
      for (m = 0; m < `IAA_NSLOT; m = m + 1) begin
        if (bus_bit && !arb[m*`IAA_ARB_W+b]) begin
          alive[m] = 1'b0;
        end
      end
    end
    win = alive;
    any = |req;
  end
endmodule

// *** rtl/iaa_ack_arb.v ***
`timescale 1ns/1ns
//
// Contract
// - Arbitration fields range 0001 lowest to 1111 highest.
// - A winner whose field is 0000 yields a spurious exception.
// - Reset: integration unit field 1111, all others 0000.
// - Integration unit field stands for all external requests.
// - Same-level requests resolved by serial contention on field bits.
// - Contention always happens; external cycle only if unit wins.
// - No contender at the level: bus error, spurious exception.
// - Start only at instruction boundary, after stacking SR and PC.
// - Function code lines read 111 during acknowledge.
// - Address: ones in 23..4, level in 3..1, one in bit 0.
// - Acknowledged level latched into priority mask.
// - Mask blocks lower-priority interrupts meanwhile.
// - Requesters respond only when their level matches.
// - Dominant internal module supplies vector and ends cycle.
// - Vector with data-size acknowledge is captured.
// - Autovector request yields a level-derived vector.
// - Bus monitor timeout gives the spurious vector.
// - Vector becomes an address; fetched word loads the PC.
// - Periodic timer served before external at the same level.
//
`include "iaa_map.vh"
module iaa_ack_arb (
  input wire clk_sys,
  input wire resetn,
  // Per internal module: level, pending, field write, vector
  input wire [`IAA_NMOD*3-1:0] mod_level,
  input wire [`IAA_NMOD-1:0] mod_pending,
  input wire [`IAA_NMOD-1:0] arb_wr,
  input wire [`IAA_NMOD*`IAA_ARB_W-1:0] arb_wdata,
  input wire [`IAA_NMOD*8-1:0] mod_vector,
  // Integration unit sources
  input wire [2:0] tick_level,
  input wire tick_pending,
  input wire [7:0] tick_vector,
  input wire [2:0] ext_level,
  input wire ext_pending,
  // External bus answers (pins)
  input wire [7:0] ext_data,
  input wire data_size_ack_n,
  input wire autovector_request_n,
  input wire bus_error_input_n,
  // Core handshake
  input wire at_boundary,
  input wire stack_done,
  input wire [15:0] handler_word,
  output reg stack_req,
  output reg [15:0] vector_fetch_addr,
  output reg vector_fetch,
  output reg [15:0] pc_load,
  output reg pc_load_en,
  output reg [2:0] function_code_lines,
  output reg [23:0] ack_addr,
  output reg ack_active,
  output reg ext_cycle,
  output reg [`IAA_NMOD-1:0] mod_ack,
  output reg [2:0] int_priority_mask,
  output reg [7:0] vector_num,
  output reg spurious,
  output reg [`IAA_NMOD*`IAA_ARB_W-1:0] arb_priority_field,
  output reg [`IAA_ARB_W-1:0] siu_arb_field
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam S_IDLE = 3'd0;
  localparam S_STACK = 3'd1;
  localparam S_ARB = 3'd2;
  localparam S_EXT = 3'd3;
  localparam S_VEC = 3'd4;
  localparam S_DONE = 3'd5;

  reg [2:0] st_q;
  reg [2:0] lvl_q;
  reg [7:0] mon_q;
  reg [2:0] ans_s1_q;
  reg [2:0] ans_s2_q;
  reg [7:0] ext_data_s1_q;
  reg [7:0] ext_data_q;

  // ----------------------------------------------------------------
  // Pin synchronisers; stage one feeds only stage two
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ans_s1_q <= `IAA_ANS_IDLE;
      ans_s2_q <= `IAA_ANS_IDLE;
      ext_data_s1_q <= `IAA_DATA_ZERO;
      ext_data_q <= `IAA_DATA_ZERO;
    end else begin
      ans_s1_q <= {bus_error_input_n, autovector_request_n,
                   data_size_ack_n};
      ans_s2_q <= ans_s1_q;
      ext_data_s1_q <= ext_data;
      ext_data_q <= ext_data_s1_q;
    end
  end
  wire data_size_ack = ~ans_s2_q[0];
  wire autovector_request = ~ans_s2_q[1];
  wire bus_error_input = ~ans_s2_q[2];

  // ----------------------------------------------------------------
  // Arbitration fields, software writable
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `IAA_NMOD; g = g + 1) begin : g_arb
      always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          arb_priority_field[g*`IAA_ARB_W +: `IAA_ARB_W] <=
            `IAA_ARB_MOD_RESET;
        end else if (arb_wr[g]) begin
          arb_priority_field[g*`IAA_ARB_W +: `IAA_ARB_W] <=
            arb_wdata[g*`IAA_ARB_W +: `IAA_ARB_W];
        end
      end
    end
  endgenerate

  // Integration unit field is fixed at its reset value here
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      siu_arb_field <= `IAA_ARB_SIU_RESET;
    end else begin
      siu_arb_field <= `IAA_ARB_SIU_RESET;
    end
  end

  // ----------------------------------------------------------------
  // Pending request level and masking
  // ----------------------------------------------------------------
  integer i;
  reg [2:0] top_lvl;
  always @* begin
    top_lvl = `IAA_LEVEL_NONE;
    for (i = 0; i < `IAA_NMOD; i = i + 1) begin
      if (mod_pending[i] && mod_level[i*3 +: 3] > top_lvl) begin
        top_lvl = mod_level[i*3 +: 3];
      end
    end
    if (tick_pending && tick_level > top_lvl) begin
      top_lvl = tick_level;
    end
    if (ext_pending && ext_level > top_lvl) begin
      top_lvl = ext_level;
    end
  end
  // Level 7 is not maskable; others must exceed the mask
  wire take = (top_lvl != `IAA_LEVEL_NONE) &&
              ((top_lvl > int_priority_mask) ||
               (top_lvl == `IAA_LEVEL_MAX));

  // ----------------------------------------------------------------
  // Contention at the acknowledged level
  // ----------------------------------------------------------------
  reg [`IAA_NMOD-1:0] req_at;
  always @* begin
    for (i = 0; i < `IAA_NMOD; i = i + 1) begin
      req_at[i] = mod_pending[i] &&
                  (mod_level[i*3 +: 3] == lvl_q);
    end
  end
  wire siu_req = (tick_pending && tick_level == lvl_q) ||
                 (ext_pending && ext_level == lvl_q);
  wire [`IAA_NMOD:0] c_req = {siu_req, req_at};
  wire [(`IAA_NMOD+1)*`IAA_ARB_W-1:0] c_arb =
    {siu_arb_field, arb_priority_field};
  wire [`IAA_NMOD:0] c_win;
  wire c_any;

  // One instance covers modules plus the integration unit slot
  iaa_contend u_cont (
    .req(c_req),
    .arb(c_arb),
    .win(c_win),
    .any(c_any)
  );

  // ----------------------------------------------------------------
  // Winner decode
  // ----------------------------------------------------------------
  integer k;
  reg [`IAA_ARB_W-1:0] win_fld;
  reg [7:0] win_vec;
  // Winners always share one field value, even when software broke the rule
  always @* begin
    win_fld = `IAA_ARB_ZERO;
    win_vec = `IAA_VEC_NONE;
    for (k = 0; k < `IAA_NSLOT; k = k + 1) begin
      if (c_win[k]) begin
        win_fld = win_fld | c_arb[k*`IAA_ARB_W +: `IAA_ARB_W];
      end
    end
    for (k = 0; k < `IAA_NMOD; k = k + 1) begin
      if (c_win[k]) begin
        win_vec = mod_vector[k*8 +: 8];
      end
    end
  end

  // Slot decode of the contention result
  wire siu_wins = c_win[`IAA_NMOD];
  wire tick_at = tick_pending && (tick_level == lvl_q);
  wire zero_win = (win_fld == `IAA_ARB_ZERO);
  wire mon_end = (mon_q == `IAA_BUSMON_CYCLES - `IAA_MON_STEP);
  wire [7:0] auto_vec = `IAA_VEC_AUTO_BASE + {`IAA_LVL_PAD, lvl_q};

  // ----------------------------------------------------------------
  // Acknowledge sequencer
  // ----------------------------------------------------------------
  // Level is frozen when the request is taken, so a source that drops
  // out while the core stacks leaves nobody to contend
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_q <= S_IDLE;
      lvl_q <= `IAA_LEVEL_NONE;
      mon_q <= `IAA_MON_ZERO;
      stack_req <= 1'b0;
      vector_fetch_addr <= `IAA_WORD_ZERO;
      vector_fetch <= 1'b0;
      pc_load <= `IAA_WORD_ZERO;
      pc_load_en <= 1'b0;
      function_code_lines <= `IAA_FC_NONE;
      ack_addr <= `IAA_ADDR_ZERO;
      ack_active <= 1'b0;
      ext_cycle <= 1'b0;
      mod_ack <= {`IAA_NMOD{1'b0}};
      int_priority_mask <= `IAA_LEVEL_NONE;
      vector_num <= `IAA_VEC_NONE;
      spurious <= 1'b0;
    end else begin
      case (st_q)
        S_IDLE: begin
          pc_load_en <= 1'b0;
          if (take && at_boundary) begin
            stack_req <= 1'b1;
            lvl_q <= top_lvl;
            st_q <= S_STACK;
          end
        end
        S_STACK: begin
          if (stack_done) begin
            stack_req <= 1'b0;
            spurious <= 1'b0;
            function_code_lines <= `IAA_FC_CPU_SPACE;
            ack_addr <= {`IAA_ADDR_HI_ONES, lvl_q, `IAA_ADDR_LSB};
            int_priority_mask <= lvl_q;
            ack_active <= 1'b1;
            st_q <= S_ARB;
          end
        end
        S_ARB: begin
          if (!c_any) begin
            // Nobody contends: the spurious monitor ends the cycle
            vector_num <= `IAA_VEC_SPURIOUS;
            spurious <= 1'b1;
            ack_active <= 1'b0;
            st_q <= S_VEC;
          end else if (zero_win) begin
            vector_num <= `IAA_VEC_SPURIOUS;
            spurious <= 1'b1;
            ack_active <= 1'b0;
            st_q <= S_VEC;
          end else if (siu_wins && tick_at) begin
            vector_num <= tick_vector;
            ack_active <= 1'b0;
            st_q <= S_VEC;
          end else if (siu_wins) begin
            ext_cycle <= 1'b1;
            mon_q <= `IAA_MON_ZERO;
            st_q <= S_EXT;
          end else begin
            mod_ack <= c_win[`IAA_NMOD-1:0];
            vector_num <= win_vec;
            ack_active <= 1'b0;
            st_q <= S_VEC;
          end
        end
        S_EXT: begin
          mon_q <= mon_q + `IAA_MON_STEP;
          if (data_size_ack) begin
            vector_num <= ext_data_q;
            ext_cycle <= 1'b0;
            ack_active <= 1'b0;
            st_q <= S_VEC;
          end else if (autovector_request) begin
            vector_num <= auto_vec;
            ext_cycle <= 1'b0;
            ack_active <= 1'b0;
            st_q <= S_VEC;
          end else if (bus_error_input || mon_end) begin
            vector_num <= `IAA_VEC_SPURIOUS;
            spurious <= 1'b1;
            ext_cycle <= 1'b0;
            ack_active <= 1'b0;
            st_q <= S_VEC;
          end
        end
        S_VEC: begin
          mod_ack <= {`IAA_NMOD{1'b0}};
          function_code_lines <= `IAA_FC_NONE;
          vector_fetch <= 1'b1;
          vector_fetch_addr <=
            {`IAA_FETCH_PAD, vector_num, `IAA_FETCH_ALIGN};
          st_q <= S_DONE;
        end
        S_DONE: begin
          vector_fetch <= 1'b0;
          pc_load <= handler_word;
          pc_load_en <= 1'b1;
          st_q <= S_IDLE;
        end
        default: begin
          st_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule

// *** tb/iaa_ack_arb_properties.sv ***
`timescale 1ns/1ns
module iaa_ack_arb_chk (
  input logic clk_sys,
  input logic resetn,
  input logic ack_active,
  input logic ext_cycle,
  input logic spurious,
  input logic vector_fetch,
  input logic [2:0] function_code_lines,
  input logic [23:0] ack_addr,
  input logic [2:0] int_priority_mask,
  input logic [7:0] vector_num,
  input logic [15:0] vector_fetch_addr,
  input logic [3:0] mod_ack,
  input logic [3:0] mod_pending,
  input logic stack_req,
  input logic [3:0] siu_arb_field
);
  // ------
  // Acknowledge cycle checks
  // ------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  AST_FC: assert property (ack_active |->
    function_code_lines == 3'h7)
    else $error("function code wrong in acknowledge");
  AST_ADDR: assert property (ack_active |->
    ack_addr[23:4] == 20'hF_FFFF && ack_addr[0])
    else $error("acknowledge address wrong");
  AST_MASK: assert property ($rose(ack_active) |->
    ##[1:4] int_priority_mask == ack_addr[3:1])
    else $error("mask not latched from address");
  AST_STACK: assert property ($rose(ack_active) |->
    $past(stack_req))
    else $error("acknowledge without stacking");
  AST_EXT: assert property (ext_cycle |-> ack_active)
    else $error("external cycle outside acknowledge");
  AST_SPUR: assert property (spurious |-> vector_num == 8'h18)
    else $error("spurious vector wrong");
  AST_FETCH: assert property (vector_fetch |->
    vector_fetch_addr == {6'h00, vector_num, 2'h0})
    else $error("vector address wrong");
  // A tie between fields would make several modules answer
  AST_ONE: assert property ($onehot0(mod_ack))
    else $error("more than one module acknowledged");
  AST_PEND: assert property ((mod_ack & ~mod_pending) == 4'h0)
    else $error("idle module acknowledged");
  AST_SIU: assert property (siu_arb_field == 4'hF)
    else $error("integration unit field not all ones");
endmodule

// *** tb/iaa_ext_dev.sv ***
`timescale 1ns/1ns
module iaa_ext_dev (
  input logic clk_sys,
  input logic ext_cycle,
  input logic [1:0] dev_mode,
  output logic [7:0] ext_data,
  output logic data_size_ack_n,
  output logic autovector_request_n,
  output logic bus_error_input_n
);
  logic [1:0] cnt_q;
  // Mode 0 stays silent so the bus monitor must end the cycle
  initial begin
    cnt_q = 2'h0;
    ext_data = 8'hA5;
    data_size_ack_n = 1'b1;
    autovector_request_n = 1'b1;
  end
  always @(posedge clk_sys) begin
    cnt_q <= ext_cycle ? (cnt_q == 2'h2 ? cnt_q : cnt_q + 2'h1) : 2'h0;
    // Answer three cycles into the cycle, after the level is decoded
    data_size_ack_n <=
      !(ext_cycle && cnt_q == 2'h2 && dev_mode == 2'h1);
    autovector_request_n <=
      !(ext_cycle && cnt_q == 2'h2 && dev_mode == 2'h2);
    ext_data <=
      (ext_cycle && dev_mode == 2'h1) ? 8'h40 : ~ext_data;
  end
  assign bus_error_input_n = 1'b1; // Pulled up
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/1ns
`include "iaa_map.vh"
module tb_top;
  logic clk_sys = 1'b0, resetn = 1'b0, tick_pending = 1'b0;
  logic ext_pending = 1'b0, at_boundary = 1'b0, stack_done = 1'b0;
  logic [11:0] mod_level = 12'h000;
  logic [3:0] mod_pending = 4'h0, arb_wr = 4'h0;
  logic [15:0] arb_wdata = 16'h0000, handler_word = 16'h1234;
  logic [31:0] mod_vector = 32'h4443_4241;
  logic [2:0] tick_level = 3'h3, ext_level = 3'h3;
  logic [7:0] tick_vector = 8'h50;
  logic [1:0] dev_mode = 2'h0;
  wire [7:0] ext_data, vector_num;
  wire data_size_ack_n, autovector_request_n, bus_error_input_n;
  wire stack_req, vector_fetch, pc_load_en, ack_active, ext_cycle, spurious;
  wire [15:0] vector_fetch_addr, pc_load, arb_priority_field;
  wire [2:0] function_code_lines, int_priority_mask;
  wire [23:0] ack_addr;
  wire [3:0] mod_ack, siu_arb_field;
  int n_mismatch = 0, cmp_count = 0;
  iaa_ack_arb u_dut (.*);
  iaa_ext_dev u_dev (.*);
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  // ------
  // Shared tasks
  // ------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("mismatches=%0d compares=%0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Reset pulse; clears the latched mask between scenarios
  task automatic do_reset;
    resetn = 1'b0;
    repeat (3) @(negedge clk_sys);
    resetn = 1'b1;
    @(negedge clk_sys);
  endtask
  // Waits well beyond the bus monitor limit before giving up
  task automatic run_ack(input logic [7:0] exp_vec);
    int i;
    at_boundary = 1'b1;
    stack_done = 1'b1;
    for (i = 0; i < 300 && pc_load_en !== 1'b1; i++) begin
      @(negedge clk_sys);
    end
    if (i == 300) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      finish_test();
    end
    check({8'h00, vector_num}, {8'h00, exp_vec});
    check(pc_load, handler_word);
    check({15'h0000, spurious}, {15'h0000, exp_vec == 8'h18});
    {at_boundary, stack_done, mod_pending} = 6'h00;
    {tick_pending, ext_pending} = 2'h0;
    repeat (4) @(negedge clk_sys);
    do_reset();
  endtask
  task automatic sc_none;
    int i;
    mod_level = 12'h140;
    mod_pending = 4'h4;
    at_boundary = 1'b1;
    for (i = 0; i < 8 && stack_req !== 1'b1; i++) begin
      @(negedge clk_sys);
    end
    mod_pending = 4'h0;
    run_ack(`IAA_VEC_SPURIOUS);
  endtask
  task automatic sc_zero;
    mod_level = 12'h140;
    mod_pending = 4'h4;
    run_ack(`IAA_VEC_SPURIOUS);
  endtask
  task automatic sc_internal;
    arb_wdata = 16'h0053;
    arb_wr = 4'h3;
    @(negedge clk_sys);
    arb_wr = 4'h0;
    check(arb_priority_field, 16'h0053);
    mod_level = 12'h02D;
    mod_pending = 4'h3;
    run_ack(8'h42);
  endtask
  task automatic sc_ext(input logic [1:0] mode, input logic [7:0] exp_vec);
    dev_mode = mode;
    ext_pending = 1'b1;
    run_ack(exp_vec);
  endtask
  task automatic sc_tick;
    {tick_pending, ext_pending} = 2'h3;
    run_ack(tick_vector);
  endtask
  initial begin
    do_reset();
    check(arb_priority_field, 16'h0000);
    sc_zero();
    sc_none();
    sc_internal();
    sc_ext(2'h1, 8'h40);
    sc_ext(2'h2, `IAA_VEC_AUTO_BASE + 8'h03);
    sc_ext(2'h0, `IAA_VEC_SPURIOUS);
    sc_tick();
    finish_test();
  end
endmodule
bind iaa_ack_arb iaa_ack_arb_chk u_chk (.*);
